// [design/host_status_lines.sv]
/*
 * Discrete status and control lines between the module and its host:
 * active-low host wake, buzzer enable, active-low radio disable with a long
 * settle time, and the status LED blink generator.
 * Assumes the radio disable pin is asynchronous to ref_clk; all other
 * inputs come from logic on ref_clk. Wake pin is a tri-state pad driven high and low:
 * three signals, output enable low while driving.
 * Assumes a pull-up outside the block holds the wake pin high while the
 * pad is released, and that the LED phase lengths come from software
 * settings that change only rarely. Every slow time is counted in whole
 * milliseconds from one shared enable pulse.
 */
// What this block does
// - Wake output high when nothing pending
// - Wake request drives wake output low
// - Trigger condition asserts wake output
// - Disable input low enters radio standby
// - Disable input high keeps radio on
// - Single buzzer enable output
// - Powered, unregistered: LED steady on
// - Registered idle: 200 ms on, 2 s off
// - Traffic: 200 ms on, 600 ms off
// - Blink rates up to 10 Hz supported
// - Software selects LED enable and periods
`default_nettype none
module host_status_lines #(
    parameter int unsigned MS_CYCLES     = status_lines_pkg::TICK_CYCLES,
    parameter int unsigned SETTLE_MS     = status_lines_pkg::SETTLE_TICKS,
    parameter int unsigned TIME_WIDTH    = 16
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Wake request from the trigger logic, level
    input  wire logic wake_trigger,
    // Pad readback of the wake pin; kept for the pad, the logic drives blind
    input  wire logic host_wake_n_in,
    output logic      host_wake_n_out,
    output logic      host_wake_n_oe_n,
    // Radio disable pin from host, active low, asynchronous
    input  wire logic radio_disable_n,
    output logic      radio_enabled,
    // Buzzer
    input  wire logic buzzer_request,
    output logic      buzzer_en,
    // Network status from the modem core
    input  wire logic powered_on,
    input  wire logic registered,
    input  wire logic traffic_active,
    // LED configuration from software settings
    // Phase lengths in ms; values under the 10 Hz floor are raised to it
    input  wire logic                  led_enable,
    input  wire logic [TIME_WIDTH-1:0] led_on_ms,
    input  wire logic [TIME_WIDTH-1:0] led_slow_off_ms,
    input  wire logic [TIME_WIDTH-1:0] led_quick_off_ms,
    output logic      status_led_out
);
    // Elaboration checks: the counters below cannot serve other values
    if (MS_CYCLES < 2) begin : g_bad_ms_cycles
        $error("host_status_lines: MS_CYCLES must be at least 2");
    end
    if (SETTLE_MS < 1) begin : g_bad_settle_ms
        $error("host_status_lines: SETTLE_MS must be at least 1");
    end
    // The phase counters must hold the longest phase, and the monitor's
    // on phase length check is done in 32-bit arithmetic
    if (TIME_WIDTH < 12) begin : g_narrow_time
        $error("host_status_lines: TIME_WIDTH must be at least 12");
    end
    if (TIME_WIDTH > 31) begin : g_wide_time
        $error("host_status_lines: TIME_WIDTH must be at most 31");
    end
    // At the real tick rate the settle point must stay inside its window
    if (MS_CYCLES == status_lines_pkg::TICK_CYCLES
        && (SETTLE_MS < status_lines_pkg::RADIO_DISABLE_SETTLE_TIME_MIN_MS
        || SETTLE_MS > status_lines_pkg::RADIO_DISABLE_SETTLE_TIME_MAX_MS)) begin : g_bad_window
        $error("host_status_lines: SETTLE_MS outside the settle window");
    end

    localparam int unsigned MS_W = $clog2(MS_CYCLES);
    localparam int unsigned ST_W = $clog2(SETTLE_MS + 1);

    // Millisecond enable pulse
    // One shared enable paces every slow counter; no second clock is made.
    // The count restarts with reset, so the first millisecond is whole.
    logic [MS_W-1:0] ms_cnt_q;
    logic            ms_tick;
    assign ms_tick = (ms_cnt_q == MS_W'(MS_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (sys_rst || ms_tick) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 1'b1;
        end
    end

    // Host wake: pin released while in reset, high idle, low on a trigger.
    // The pin value comes straight from a flop so the host never sees a
    // combinational glitch on its wake line.
    logic wake_n_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wake_n_q <= 1'b1;
        end else begin
            wake_n_q <= ~wake_trigger;
        end
    end

    assign host_wake_n_out = wake_n_q;

    // The pad is released for the whole reset and one cycle beyond it, so
    // the first driven value is already the settled idle level.
    // No reset branch: this flop only copies the reset line.
    logic reset_seen_q;
    always_ff @(posedge ref_clk) begin
        reset_seen_q <= sys_rst;
    end
    assign host_wake_n_oe_n = sys_rst | reset_seen_q;

    // Radio disable: two-stage synchroniser, then settle counter
    // Only the second flop is read; the first may still be resolving
    logic dis_meta_q;
    logic dis_sync_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dis_meta_q <= 1'b1;
            dis_sync_q <= 1'b1;
        end else begin
            dis_meta_q <= radio_disable_n;
            dis_sync_q <= dis_meta_q;
        end
    end

    // Any change of level restarts the settle count, so glitches never act.
    // The host must therefore hold each level for the full settle time.
    // The settle point sits in the middle of the allowed window, which
    // leaves margin on both sides for the phase of the time base.
    logic            dis_last_q;
    logic [ST_W-1:0] settle_q;
    logic            level_moved;
    logic            level_differs;
    logic            settle_done;

    assign level_moved   = (dis_sync_q != dis_last_q);
    assign level_differs = (dis_sync_q != radio_enabled);
    assign settle_done   = ms_tick && !level_moved && level_differs
                        && (settle_q == ST_W'(SETTLE_MS - 1));

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dis_last_q <= 1'b1;
        end else begin
            dis_last_q <= dis_sync_q;
        end
    end

    // Counts whole milliseconds while the synchronised level differs;
    // a level that returns to the current mode clears the count
    always_ff @(posedge ref_clk) begin
        if (sys_rst || level_moved || !level_differs || settle_done) begin
            settle_q <= '0;
        end else if (ms_tick) begin
            settle_q <= settle_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            radio_enabled <= status_lines_pkg::RADIO_ON_RESET;
        end else if (settle_done) begin
            radio_enabled <= dis_sync_q;
        end
    end

    // Buzzer: one binary line
    // Registered so the buzzer line only moves on a clock edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            buzzer_en <= 1'b0;
        end else begin
            buzzer_en <= buzzer_request;
        end
    end

    // LED pattern selection
    // Traffic outranks registration, which outranks power alone;
    // an unpowered module has nothing to report, so the LED stays dark
    status_lines_pkg::led_pattern_type want_pat;
    always_comb begin
        if (!led_enable || !powered_on) begin
            want_pat = status_lines_pkg::LED_PAT_OFF;
        end else if (registered && traffic_active) begin
            want_pat = status_lines_pkg::LED_PAT_QUICK;
        end else if (registered) begin
            want_pat = status_lines_pkg::LED_PAT_SLOW;
        end else begin
            want_pat = status_lines_pkg::LED_PAT_STEADY;
        end
    end

    // Times below the 10 Hz limit are clamped to keep each phase >= 50 ms
    // Clamping trades exact short phases for a flash that is always visible
    localparam logic [TIME_WIDTH-1:0] MIN_PHASE =
        TIME_WIDTH'(status_lines_pkg::MIN_PERIOD_MS / 2);
    function automatic logic [TIME_WIDTH-1:0] clamp(input logic [TIME_WIDTH-1:0] t);
        clamp = (t < MIN_PHASE) ? MIN_PHASE : t;
    endfunction

    status_lines_pkg::led_pattern_type pat_q;
    logic                  phase_on_q;
    logic [TIME_WIDTH-1:0] phase_cnt_q;
    logic [TIME_WIDTH-1:0] on_len;
    logic [TIME_WIDTH-1:0] off_len;
    logic                  phase_done;
    logic                  period_end;

    logic [TIME_WIDTH-1:0] phase_len;

    assign on_len = clamp(led_on_ms);

    // Only the quick pattern has its own off time
    always_comb begin
        if (pat_q == status_lines_pkg::LED_PAT_QUICK) begin
            off_len = clamp(led_quick_off_ms);
        end else begin
            off_len = clamp(led_slow_off_ms);
        end
    end

    always_comb begin
        if (phase_on_q) begin
            phase_len = on_len;
        end else begin
            phase_len = off_len;
        end
    end

    assign phase_done = ms_tick && (phase_cnt_q == phase_len - 1'b1);

    // Steady and off have no period; a blink pattern ends after its off phase
    always_comb begin
        if (pat_q == status_lines_pkg::LED_PAT_OFF) begin
            period_end = 1'b1;
        end else if (pat_q == status_lines_pkg::LED_PAT_STEADY) begin
            period_end = 1'b1;
        end else begin
            period_end = phase_done && !phase_on_q;
        end
    end

    // A pattern change waits for the end of the running period so the host
    // never sees a shortened flash; disabling the LED acts at once.
    logic pat_switch;
    logic phase_restart;
    assign pat_switch    = period_end && (want_pat != pat_q);
    assign phase_restart = pat_switch || !led_enable;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pat_q <= status_lines_pkg::LED_PAT_OFF;
        end else if (pat_switch) begin
            pat_q <= want_pat;
        end else if (!led_enable) begin
            pat_q <= status_lines_pkg::LED_PAT_OFF;
        end
    end

    // Every pattern starts with its on phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst || phase_restart) begin
            phase_on_q <= 1'b1;
        end else if (phase_done) begin
            phase_on_q <= ~phase_on_q;
        end
    end

    // Counts whole milliseconds of the running phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst || phase_restart || phase_done) begin
            phase_cnt_q <= '0;
        end else if (ms_tick) begin
            phase_cnt_q <= phase_cnt_q + 1'b1;
        end
    end

    // Registered so a pattern switch never leaves a runt pulse on the pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_led_out <= status_lines_pkg::LED_RESET;
        end else begin
            unique case (pat_q)
                status_lines_pkg::LED_PAT_OFF:    status_led_out <= 1'b0;
                status_lines_pkg::LED_PAT_STEADY: status_led_out <= 1'b1;
                status_lines_pkg::LED_PAT_SLOW,
                status_lines_pkg::LED_PAT_QUICK:  status_led_out <= phase_on_q;
            endcase
        end
    end
endmodule // host_status_lines
`default_nettype wire

// [design/status_lines_pkg.sv]
/*
 * Constants for the host status lines block: time base, debounce window,
 * LED blink pattern times and LED mode encodings.
 * Assumes a single 125 MHz clock; all times are converted to tick counts here.
 */
`default_nettype none
package status_lines_pkg;
    // Clock rate and the 1 ms time base
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    // Radio disable settle window, in ms; the settle point lies inside it
    localparam int unsigned RADIO_DISABLE_SETTLE_TIME_MIN_MS = 5000;
    localparam int unsigned RADIO_DISABLE_SETTLE_TIME_MAX_MS = 7000;
    localparam int unsigned SETTLE_TICKS    = RADIO_DISABLE_SETTLE_TIME_MIN_MS
                                            + (RADIO_DISABLE_SETTLE_TIME_MAX_MS
                                            - RADIO_DISABLE_SETTLE_TIME_MIN_MS) / 2;
    // LED pattern times in ms
    localparam int unsigned LED_ON_MS       = 200;
    localparam int unsigned SLOW_OFF_MS     = 2000;
    localparam int unsigned QUICK_OFF_MS    = 600;
    // Fastest blink supported: 10 Hz means a 100 ms full period
    localparam int unsigned MAX_BLINK_HZ    = 10;
    localparam int unsigned MIN_PERIOD_MS   = 1000 / MAX_BLINK_HZ;
    // Reset values
    localparam logic        RADIO_ON_RESET  = 1'b1;
    localparam logic        LED_RESET       = 1'b0;

    typedef enum logic [1:0] {
        LED_PAT_OFF,
        LED_PAT_STEADY,
        LED_PAT_SLOW,
        LED_PAT_QUICK
    } led_pattern_type;
endpackage
`default_nettype wire

// [tb/status_lines_monitor.sv]
/* Port checker for host_status_lines, bound into every instance.
   Assumes one ref_clk domain and a host that holds each radio level. */
`default_nettype none
module status_lines_monitor #(
    parameter int unsigned MS_CYCLES  = 10,
    parameter int unsigned SETTLE_MS  = 5,
    parameter int unsigned TIME_WIDTH = 16
) (
    input wire logic ref_clk, sys_rst, wake_trigger, host_wake_n_out, host_wake_n_oe_n,
    input wire logic radio_disable_n, radio_enabled, buzzer_request, buzzer_en,
    input wire logic registered, led_enable, status_led_out,
    input wire logic [TIME_WIDTH-1:0] led_on_ms
);
    timeunit 1ns;
    timeprecision 1ps;
    // Window of the settled change, counted from eight stable samples
    localparam int LO   = (SETTLE_MS - 1) * MS_CYCLES - 8;
    localparam int SPAN = 2 * MS_CYCLES + 8;
    logic [31:0] on_cnt_q;
    always_ff @(posedge ref_clk) on_cnt_q <= status_led_out ? on_cnt_q + 32'h1 : 32'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence held_s(logic v);
        radio_disable_n != v && radio_enabled != v ##1 (radio_disable_n == v) [*8];
    endsequence
    sequence settle_s(logic v);
        ##LO radio_enabled != v ##[1:SPAN] radio_enabled == v;
    endsequence
    a_wake_idle: assert property (!wake_trigger |=> host_wake_n_out)
        else $error("wake pin low without trigger");
    a_wake_request: assert property (wake_trigger |=> !host_wake_n_out)
        else $error("wake pin not low after trigger");
    a_reset_float: assert property (disable iff (1'b0) sys_rst |-> host_wake_n_oe_n)
        else $error("wake pin driven in reset");
    a_buzzer_follow: assert property (1'b1 |=> buzzer_en == $past(buzzer_request))
        else $error("buzzer enable wrong");
    a_radio_level: assert property ($changed(radio_enabled)
        |-> radio_enabled == radio_disable_n)
        else $error("radio mode against pin level");
    a_radio_off: assert property (held_s(1'b0) |-> settle_s(1'b0))
        else $error("standby entry time wrong");
    a_radio_on: assert property (held_s(1'b1) |-> settle_s(1'b1))
        else $error("radio restore time wrong");
    a_led_gate: assert property (!led_enable [*3] |-> !status_led_out)
        else $error("led lit while disabled");
    a_led_on_width: assert property ($fell(status_led_out) && led_enable
        && registered |-> on_cnt_q >= (led_on_ms - 1) * MS_CYCLES
        && on_cnt_q <= (led_on_ms + 1) * MS_CYCLES + 3)
        else $error("led on phase length wrong");
endmodule // status_lines_monitor
bind host_status_lines status_lines_monitor #(.MS_CYCLES(MS_CYCLES), .SETTLE_MS(SETTLE_MS),
    .TIME_WIDTH(TIME_WIDTH)) status_lines_monitor_i (.*);
`default_nettype wire

// [tb/host_model.sv]
/* Host side model: drives the radio disable pin, counts wake requests.
   Assumes the wake pin arrives already resolved with its pull-up. */
`default_nettype none
module host_model (
    input  wire logic ref_clk,
    input  wire logic host_wake_n,
    output var logic  radio_disable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int wake_edges = 0;
    initial radio_disable_n = 1'b1;
    always @(negedge host_wake_n) wake_edges++;
    task automatic hold_level(input logic lvl, input int hold);
        @(posedge ref_clk);
        radio_disable_n <= lvl;
        repeat (hold) @(posedge ref_clk);
    endtask
endmodule // host_model
`default_nettype wire

// [tb/testbench.sv]
/* Self-checking bench for host_status_lines with the host model.
   Time base cut to 10 cycles a ms and a 5 ms settle to keep runs short. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic ref_clk = 1'b0, sys_rst = 1'b1, wake_trigger = 1'b0, buzzer_request = 1'b0;
    logic powered_on = 1'b0, registered = 1'b0, traffic_active = 1'b0, led_enable = 1'b1;
    logic host_wake_n_out, host_wake_n_oe_n, radio_disable_n, radio_enabled;
    logic buzzer_en, status_led_out;
    // Pull-up on the wake pin when released
    wire logic wake_pin = host_wake_n_oe_n ? 1'b1 : host_wake_n_out;
    int failures = 0, n_tests = 0;
    always #4 ref_clk = ~ref_clk;
    host_status_lines #(.MS_CYCLES(MS), .SETTLE_MS(5)) host_status_lines_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .wake_trigger(wake_trigger),
        .host_wake_n_in(wake_pin), .host_wake_n_out(host_wake_n_out),
        .host_wake_n_oe_n(host_wake_n_oe_n), .radio_disable_n(radio_disable_n),
        .radio_enabled(radio_enabled), .buzzer_request(buzzer_request), .buzzer_en(buzzer_en),
        .powered_on(powered_on), .registered(registered), .traffic_active(traffic_active),
        .led_enable(led_enable), .led_on_ms(16'h0032), .led_slow_off_ms(16'h0064),
        .led_quick_off_ms(16'h003c), .status_led_out(status_led_out));
    host_model host_model_i (.ref_clk(ref_clk), .host_wake_n(wake_pin),
        .radio_disable_n(radio_disable_n));
    task automatic chk(input string name, input logic [31:0] lo, hi, got);
        n_tests++;
        if (^got === 1'bx || got < lo || got > hi) begin
            failures++;
            $display("[FAIL] %s expected %0d..%0d seen %0h", name, lo, hi, got);
        end
    endtask
    task automatic run_len(output int n);
        logic v;
        v = status_led_out;
        n = 0;
        while (status_led_out === v && n < 3000) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask
    task automatic t_wake_buzz;
        @(posedge ref_clk);
        wake_trigger <= 1'b1;
        @(posedge ref_clk);
        #1 chk("wake pin", 0, 0, wake_pin);
        chk("wake edges", 1, 1, host_model_i.wake_edges);
        @(posedge ref_clk);
        wake_trigger <= 1'b0;
        buzzer_request <= 1'b1;
        @(posedge ref_clk);
        #1 chk("wake pin", 1, 1, wake_pin);
        chk("buzzer", 1, 1, buzzer_en);
        $display("t_wake_buzz done");
    endtask
    task automatic t_radio;
        host_model_i.hold_level(1'b0, 4);
        host_model_i.hold_level(1'b1, 70);
        #1 chk("radio after glitch", 1, 1, radio_enabled);
        for (int i = 0; i < 2; i++) begin
            host_model_i.hold_level(i[0], 38);
            #1 chk("radio early", !i[0], !i[0], radio_enabled);
            repeat (30) @(posedge ref_clk);
            #1 chk("radio settled", i[0], i[0], radio_enabled);
        end
        $display("t_radio done");
    endtask
    task automatic t_led;
        int n;
        @(posedge ref_clk);
        #1 chk("led unpowered", 0, 0, status_led_out);
        @(posedge ref_clk);
        powered_on <= 1'b1;
        registered <= 1'b1;
        run_len(n);
        run_len(n);
        chk("slow on", 49 * MS, 51 * MS + 3, n);
        traffic_active <= 1'b1;
        run_len(n);
        chk("slow off", 99 * MS, 101 * MS + 3, n);
        run_len(n);
        run_len(n);
        chk("quick off", 59 * MS, 61 * MS + 3, n);
        registered <= 1'b0;
        traffic_active <= 1'b0;
        repeat (3) run_len(n);
        chk("steady on", 3000, 3000, n);
        led_enable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("led disabled", 0, 0, status_led_out);
        $display("t_led done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        chk("wake enable", 1, 1, host_wake_n_oe_n);
        sys_rst <= 1'b0;
        t_wake_buzz();
        t_radio();
        t_led();
        give_verdict();
    end
    initial begin
        #240000;
        failures++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
